//--- hdl/tmcc_consts.vh
// Constants shared by the timer core: register map, fields, codes, timing
`ifndef TMCC_CONSTS_VH
`define TMCC_CONSTS_VH

// ****************************************************************
// Counter widths
// ****************************************************************
`define TMCC_CNT_W_CE      10
`define TMCC_CNT_W_STD     16

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define TMCC_ADR_CTRL      8'h00
`define TMCC_ADR_CMPA      8'h04
`define TMCC_ADR_CMPB      8'h08
`define TMCC_ADR_CMPP      8'h0c
`define TMCC_ADR_COUNT     8'h10
`define TMCC_ADR_STAT      8'h14
`define TMCC_ADR_MASK      8'h18
`define TMCC_ADR_PENA      8'h1c
`define TMCC_ADR_PENB      8'h20

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define TMCC_CTRL_W        10
`define TMCC_CTRL_CKS      2:0
`define TMCC_CTRL_CLRP     3
`define TMCC_CTRL_CLRA     4
`define TMCC_CTRL_ACT      6:5
`define TMCC_CTRL_PWM      7
`define TMCC_CTRL_POL0     8
`define TMCC_CTRL_POL1     9
`define TMCC_CTRL_RST      10'h005

// ****************************************************************
// Clock select codes
// ****************************************************************
`define TMCC_CKS_SYS4      3'h0
`define TMCC_CKS_SYS       3'h1
`define TMCC_CKS_FH16      3'h2
`define TMCC_CKS_FH64      3'h3
`define TMCC_CKS_TBC       3'h4
`define TMCC_CKS_RSVD      3'h5
`define TMCC_CKS_EXTR      3'h6
`define TMCC_CKS_EXTF      3'h7

// Prescaler masks: tick when all masked bits are one
`define TMCC_PRE_W         8
`define TMCC_PRE_M_SYS4    8'h03
`define TMCC_PRE_M_FH16    8'h0f
`define TMCC_PRE_M_FH64    8'h3f

// ****************************************************************
// Output actions
// ****************************************************************
`define TMCC_ACT_NONE      2'h0
`define TMCC_ACT_LOW       2'h1
`define TMCC_ACT_HIGH      2'h2
`define TMCC_ACT_TOG       2'h3

// ****************************************************************
// Interrupt bits and pin enables
// ****************************************************************
`define TMCC_IRQ_W         3
`define TMCC_IRQ_A         0
`define TMCC_IRQ_B         1
`define TMCC_IRQ_P         2
`define TMCC_PEN_W         8
`define TMCC_PENA_RST      8'h91
`define TMCC_PENB_RST      8'h11
`define TMCC_PEN_OUT0      0
`define TMCC_PEN_OUT1      1
`define TMCC_PEN_IN        0

`endif

//--- hdl/tmcc_clk_src.v
// Counter clock source selection, prescaler and external pin edge detect
`timescale 1ns/10ps
`default_nettype none
`include "tmcc_consts.vh"

module tmcc_clk_src
(
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire [2:0] sel_i,
    input  wire       pin_en_i,
    input  wire       ext_pin_i,
    input  wire       tbc_tick_i,
    output reg        tick_o
);

    reg  [`TMCC_PRE_W-1:0] pre_ff;
    reg                    s1_ff;
    reg                    s2_ff;
    reg                    s3_ff;
    reg                    lvl_ff;
    reg                    nxt_tick;
    wire                   rise;
    wire                   fall;

    // A level counts only once second and third stage agree
    assign rise = (s2_ff == s3_ff) & s2_ff & ~lvl_ff;
    assign fall = (s2_ff == s3_ff) & ~s2_ff & lvl_ff;

    always @*
    begin
        nxt_tick = 1'b0;
        case (sel_i)
            `TMCC_CKS_SYS4:
                nxt_tick = (pre_ff & `TMCC_PRE_M_SYS4) == `TMCC_PRE_M_SYS4;
            `TMCC_CKS_SYS:  nxt_tick = 1'b1;
            `TMCC_CKS_FH16:
                nxt_tick = (pre_ff & `TMCC_PRE_M_FH16) == `TMCC_PRE_M_FH16;
            `TMCC_CKS_FH64:
                nxt_tick = (pre_ff & `TMCC_PRE_M_FH64) == `TMCC_PRE_M_FH64;
            `TMCC_CKS_TBC:  nxt_tick = tbc_tick_i;
            `TMCC_CKS_RSVD: nxt_tick = 1'b0;
            `TMCC_CKS_EXTR: nxt_tick = pin_en_i & rise;
            `TMCC_CKS_EXTF: nxt_tick = pin_en_i & fall;
            default:        nxt_tick = 1'b0;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pre_ff <= {`TMCC_PRE_W{1'b0}};
            s1_ff  <= 1'b0;
            s2_ff  <= 1'b0;
            s3_ff  <= 1'b0;
            lvl_ff <= 1'b0;
            tick_o <= 1'b0;
        end
        else
        begin
            pre_ff <= pre_ff + 1'b1;
            s1_ff  <= ext_pin_i;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            if (s2_ff == s3_ff)
                lvl_ff <= s2_ff;
            tick_o <= nxt_tick;
        end
    end

endmodule
`default_nettype wire

//--- hdl/tmcc_out_ctl.v
// Timer output level: compare match actions and edge aligned PWM
`timescale 1ns/10ps
`default_nettype none
`include "tmcc_consts.vh"

module tmcc_out_ctl
(
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       pwm_i,
    input  wire [1:0] act_i,
    input  wire       match_a_i,
    input  wire       wrap_i,
    output reg        out_o
);

    reg nxt_out;

    always @*
    begin
        nxt_out = out_o;
        if (pwm_i)
        begin
            if (match_a_i)
                nxt_out = 1'b0;
            else if (wrap_i)
                nxt_out = 1'b1;
        end
        else if (match_a_i)
        begin
            case (act_i)
                `TMCC_ACT_LOW:  nxt_out = 1'b0;
                `TMCC_ACT_HIGH: nxt_out = 1'b1;
                `TMCC_ACT_TOG:  nxt_out = ~out_o;
                default:        nxt_out = out_o;
            endcase
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
            out_o <= 1'b0;
        else
            out_o <= nxt_out;
    end

endmodule
`default_nettype wire

//--- hdl/tmcc_top.v
// Timer module common core with Wishbone registers and shared pins
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "tmcc_consts.vh"

module tmcc_top
#(
    parameter CNT_W    = `TMCC_CNT_W_CE,
    parameter HAS_CMPB = 1
)
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        ext_count_clock_pin_i,
    input  wire        time_base_clock_i,
    input  wire [1:0]  alt_out_i,
    input  wire [1:0]  alt_oe_i,
    output reg  [1:0]  timer_output_pin_o,
    output reg  [1:0]  timer_output_pin_oe_o,
    output reg         irq_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Byte-lane merge of a write into a register of up to 16 bits
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] d;
        input [3:0]  sel;
        begin
            merge16 = {sel[1] ? d[15:8] : old[15:8],
                       sel[0] ? d[7:0]  : old[7:0]};
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    reg  [`TMCC_CTRL_W-1:0] timer_control_reg0_ff;
    reg  [CNT_W-1:0]        cmp_a_ff;
    reg  [CNT_W-1:0]        cmp_b_ff;
    reg  [CNT_W-1:0]        cmp_p_ff;
    reg  [CNT_W-1:0]        cnt_ff;
    reg  [`TMCC_IRQ_W-1:0]  stat_ff;
    reg  [`TMCC_IRQ_W-1:0]  mask_ff;
    reg  [`TMCC_PEN_W-1:0]  timer_pin_enable_a_ff;
    reg  [`TMCC_PEN_W-1:0]  timer_pin_enable_b_ff;

    reg  [CNT_W-1:0]        nxt_cnt;
    reg  [`TMCC_IRQ_W-1:0]  nxt_stat;
    reg  [`TMCC_IRQ_W-1:0]  nxt_mask;
    reg  [31:0]             nxt_rdata;
    reg  [1:0]              nxt_pin;
    reg  [1:0]              nxt_oe;

    wire                    acc;
    wire                    wr;
    wire                    nxt_ack;
    wire [15:0]             wval_ctrl;
    wire [15:0]             wval_a;
    wire [15:0]             wval_b;
    wire [15:0]             wval_p;
    wire [15:0]             wval_mask;
    wire [15:0]             wval_pena;
    wire [15:0]             wval_penb;
    wire [`TMCC_IRQ_W-1:0]  w1c;
    wire [`TMCC_IRQ_W-1:0]  events;
    wire                    tick;
    wire                    clr;
    wire                    wrap;
    wire                    match_a;
    wire                    match_b;
    wire                    match_p;
    wire                    has_b;
    wire                    tout;

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    // Writes land on the edge where the master sees ack
    assign acc     = wb_cyc_i & wb_stb_i;
    assign nxt_ack = acc & ~wb_ack_o;
    assign wr      = acc & wb_we_i & wb_ack_o;

    assign wval_ctrl = merge16({6'h00, timer_control_reg0_ff},
                               wb_dat_i, wb_sel_i);
    assign wval_a    = merge16({{(16-CNT_W){1'b0}}, cmp_a_ff},
                               wb_dat_i, wb_sel_i);
    assign wval_b    = merge16({{(16-CNT_W){1'b0}}, cmp_b_ff},
                               wb_dat_i, wb_sel_i);
    assign wval_p    = merge16({{(16-CNT_W){1'b0}}, cmp_p_ff},
                               wb_dat_i, wb_sel_i);
    assign wval_mask = merge16({13'h0000, mask_ff}, wb_dat_i, wb_sel_i);
    assign wval_pena = merge16({8'h00, timer_pin_enable_a_ff},
                               wb_dat_i, wb_sel_i);
    assign wval_penb = merge16({8'h00, timer_pin_enable_b_ff},
                               wb_dat_i, wb_sel_i);

    assign w1c = (wr && wb_adr_i == `TMCC_ADR_STAT && wb_sel_i[0])
                 ? wb_dat_i[`TMCC_IRQ_W-1:0] : {`TMCC_IRQ_W{1'b0}};

    always @*
    begin
        case (wb_adr_i)
            `TMCC_ADR_CTRL:
                nxt_rdata = {22'h000000, timer_control_reg0_ff};
            `TMCC_ADR_CMPA:
                nxt_rdata = {{(32-CNT_W){1'b0}}, cmp_a_ff};
            `TMCC_ADR_CMPB:
                nxt_rdata = {{(32-CNT_W){1'b0}}, cmp_b_ff};
            `TMCC_ADR_CMPP:
                nxt_rdata = {{(32-CNT_W){1'b0}}, cmp_p_ff};
            `TMCC_ADR_COUNT:
                nxt_rdata = {{(32-CNT_W){1'b0}}, cnt_ff};
            `TMCC_ADR_STAT:
                nxt_rdata = {29'h00000000, stat_ff};
            `TMCC_ADR_MASK:
                nxt_rdata = {29'h00000000, mask_ff};
            `TMCC_ADR_PENA:
                nxt_rdata = {24'h000000, timer_pin_enable_a_ff};
            `TMCC_ADR_PENB:
                nxt_rdata = {24'h000000, timer_pin_enable_b_ff};
            default:
                nxt_rdata = 32'h00000000;
        endcase
    end

    // ****************************************************************
    // Clock source
    // ****************************************************************
    // clock select
    tmcc_clk_src u_clk_src
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .sel_i      (timer_control_reg0_ff[`TMCC_CTRL_CKS]),
        .pin_en_i   (timer_pin_enable_b_ff[`TMCC_PEN_IN]),
        .ext_pin_i  (ext_count_clock_pin_i),
        .tbc_tick_i (time_base_clock_i),
        .tick_o     (tick)
    );

    // ****************************************************************
    // Counter and comparators
    // ****************************************************************
    assign has_b = (HAS_CMPB != 0);

    assign clr = tick &
        ((timer_control_reg0_ff[`TMCC_CTRL_CLRP] & (cnt_ff == cmp_p_ff)) |
         (timer_control_reg0_ff[`TMCC_CTRL_CLRA] & (cnt_ff == cmp_a_ff)));

    always @*
    begin
        if (clr)
            nxt_cnt = {CNT_W{1'b0}};
        else if (tick)
            nxt_cnt = cnt_ff + 1'b1;
        else
            nxt_cnt = cnt_ff;
    end

    assign match_a = tick & (nxt_cnt == cmp_a_ff);
    assign match_p = tick & (nxt_cnt == cmp_p_ff);
    assign match_b = tick & has_b & (nxt_cnt == cmp_b_ff);
    assign wrap    = tick & (nxt_cnt == {CNT_W{1'b0}});

    assign events = {match_p, match_b, match_a};

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    always @*
    begin
        // match sets interrupt; set beats clear
        nxt_stat = (stat_ff & ~w1c) | events;
        nxt_mask = mask_ff;
        if (wr && wb_adr_i == `TMCC_ADR_MASK)
            nxt_mask = wval_mask[`TMCC_IRQ_W-1:0];
    end

    // ****************************************************************
    // Output pins
    // ****************************************************************
    tmcc_out_ctl u_out_ctl
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .pwm_i     (timer_control_reg0_ff[`TMCC_CTRL_PWM]),
        .act_i     (timer_control_reg0_ff[`TMCC_CTRL_ACT]),
        .match_a_i (match_a),
        .wrap_i    (wrap),
        .out_o     (tout)
    );

    always @*
    begin
        if (timer_pin_enable_a_ff[`TMCC_PEN_OUT0])
        begin
            nxt_pin[0] = tout ^ timer_control_reg0_ff[`TMCC_CTRL_POL0];
            nxt_oe[0]  = 1'b1;
        end
        else
        begin
            nxt_pin[0] = alt_out_i[0];
            nxt_oe[0]  = alt_oe_i[0];
        end
        if (timer_pin_enable_a_ff[`TMCC_PEN_OUT1])
        begin
            nxt_pin[1] = tout ^ timer_control_reg0_ff[`TMCC_CTRL_POL1];
            nxt_oe[1]  = 1'b1;
        end
        else
        begin
            nxt_pin[1] = alt_out_i[1];
            nxt_oe[1]  = alt_oe_i[1];
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_control_reg0_ff <= `TMCC_CTRL_RST;
            cmp_a_ff              <= {CNT_W{1'b0}};
            cmp_b_ff              <= {CNT_W{1'b0}};
            cmp_p_ff              <= {CNT_W{1'b0}};
            cnt_ff                <= {CNT_W{1'b0}};
            stat_ff               <= {`TMCC_IRQ_W{1'b0}};
            mask_ff               <= {`TMCC_IRQ_W{1'b0}};
            timer_pin_enable_a_ff <= `TMCC_PENA_RST;
            timer_pin_enable_b_ff <= `TMCC_PENB_RST;
            wb_ack_o              <= 1'b0;
            wb_dat_o              <= 32'h00000000;
            timer_output_pin_o    <= 2'h0;
            timer_output_pin_oe_o <= 2'h0;
            irq_o                 <= 1'b0;
        end
        else
        begin
            wb_ack_o <= nxt_ack;
            if (nxt_ack)
                wb_dat_o <= nxt_rdata;
            if (wr)
            begin
                case (wb_adr_i)
                    `TMCC_ADR_CTRL:
                        timer_control_reg0_ff <=
                            wval_ctrl[`TMCC_CTRL_W-1:0];
                    `TMCC_ADR_CMPA: cmp_a_ff <= wval_a[CNT_W-1:0];
                    `TMCC_ADR_CMPB: cmp_b_ff <= wval_b[CNT_W-1:0];
                    `TMCC_ADR_CMPP: cmp_p_ff <= wval_p[CNT_W-1:0];
                    `TMCC_ADR_PENA:
                        timer_pin_enable_a_ff <=
                            wval_pena[`TMCC_PEN_W-1:0];
                    `TMCC_ADR_PENB:
                        timer_pin_enable_b_ff <=
                            wval_penb[`TMCC_PEN_W-1:0];
                    default:
                        cnt_ff <= nxt_cnt;
                endcase
            end
            // Counter keeps running through register writes
            cnt_ff                <= nxt_cnt;
            stat_ff               <= nxt_stat;
            mask_ff               <= nxt_mask;
            irq_o                 <= |(nxt_stat & nxt_mask);
            timer_output_pin_o    <= nxt_pin;
            timer_output_pin_oe_o <= nxt_oe;
        end
    end

endmodule
`default_nettype wire

//--- tb/tmcc_pin_partner.sv
// Pin-side partner: external count pin and the other shared pin function
`timescale 1ns/10ps
`default_nettype none

module tmcc_pin_partner
(
    input  wire logic       clk_i,
    output var  logic       ext_o,
    output wire logic [1:0] alt_out_o,
    output wire logic [1:0] alt_oe_o
);
    logic [3:0] pat_ff;

    initial
    begin
        ext_o  = 1'b0;
        pat_ff = 4'h0;
    end

    // other function drive
    // Moves every cycle, so a stale pass-through cannot hide
    always @(posedge clk_i)
        pat_ff <= pat_ff + 4'h1;
    assign alt_out_o = pat_ff[1:0];
    assign alt_oe_o  = pat_ff[3:2];

    // both edges offered
    // Starts by pulling low; optionally ends on a lone rising edge
    task automatic pulses(input int n, input bit end_hi);
        ext_o <= 1'b0;
        repeat (n)
        begin
            repeat (6) @(posedge clk_i);
            ext_o <= 1'b1;
            repeat (6) @(posedge clk_i);
            ext_o <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
        if (end_hi)
            ext_o <= 1'b1;
        repeat (10) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

//--- tb/tmcc_top_properties.sv
// Bus, pin and interrupt properties of the timer core
`timescale 1ns/10ps
`default_nettype none
`include "tmcc_consts.vh"

module tmcc_top_props
#(
    parameter CNT_W    = 10,
    parameter HAS_CMPB = 1
)
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        ext_count_clock_pin_i,
    input wire logic        time_base_clock_i,
    input wire logic [1:0]  alt_out_i,
    input wire logic [1:0]  alt_oe_i,
    input wire logic [1:0]  timer_output_pin_o,
    input wire logic [1:0]  timer_output_pin_oe_o,
    input wire logic        irq_o
);
    logic [9:0] ctrl_ff;
    logic [7:0] pena_ff;
    logic [2:0] mask_ff;
    logic       mset_ff;
    logic [1:0] quiet_ff;
    logic       wr;

    // Register shadow; quiet counts settled cycles since any write
    assign wr = wb_ack_o & wb_we_i;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff  <= `TMCC_CTRL_RST;
            pena_ff  <= `TMCC_PENA_RST;
            mask_ff  <= 3'h0;
            mset_ff  <= 1'b0;
            quiet_ff <= 2'h0;
        end
        else
        begin
            quiet_ff <= wr ? 2'h0 : quiet_ff + {1'b0, quiet_ff != 2'h3};
            if (wr && wb_adr_i == `TMCC_ADR_CTRL)
                ctrl_ff <= {wb_sel_i[1] ? wb_dat_i[9:8] : ctrl_ff[9:8],
                            wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_ff[7:0]};
            if (wr && wb_adr_i == `TMCC_ADR_PENA && wb_sel_i[0])
                pena_ff <= wb_dat_i[7:0];
            if (wr && wb_adr_i == `TMCC_ADR_MASK && wb_sel_i[0])
                mask_ff <= wb_dat_i[2:0];
            if (wr && wb_adr_i == `TMCC_ADR_MASK && wb_sel_i[0])
                mset_ff <= 1'b1;
        end
    end

    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_ack_cause:
        assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
        else $error("ack without request");
    chk_ack_next:
        assert property ($rose(wb_cyc_i & wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    chk_unmap_zero:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i > `TMCC_ADR_PENB
            |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    chk_ctrl_readback:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i == `TMCC_ADR_CTRL
            |-> wb_dat_o[9:0] == ctrl_ff) else $error("control readback");
    chk_pin_owned:
        assert property (quiet_ff == 2'h3 && pena_ff[0]
            |-> timer_output_pin_oe_o[0]) else $error("pin0 not driven");
    chk_alt_enable:
        assert property (quiet_ff == 2'h3 && !pena_ff[1]
            |-> timer_output_pin_oe_o[1] == $past(alt_oe_i[1]))
        else $error("pin1 enable not passed");
    chk_alt_level:
        assert property (quiet_ff == 2'h3 && !pena_ff[1]
            |-> timer_output_pin_o[1] == $past(alt_out_i[1]))
        else $error("pin1 level not passed");
    chk_pair_polarity:
        assert property (quiet_ff == 2'h3 && pena_ff[1:0] == 2'h3
            |-> ^timer_output_pin_o == ^ctrl_ff[9:8])
        else $error("pin pair polarity");
    chk_irq_masked:
        assert property (quiet_ff == 2'h3 && mset_ff && mask_ff == 3'h0
            |-> !irq_o) else $error("irq while masked");
endmodule

`default_nettype wire

//--- tb/tmcc_tb_top.sv
// Self-checking bench for the timer common core
`timescale 1ns/10ps
`default_nettype none
`include "tmcc_consts.vh"

module tmcc_tb_top;
    localparam CNT_W = `TMCC_CNT_W_CE;
    localparam logic [31:0] CMAX = (1 << CNT_W) - 1;

    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        tbc;
    logic [2:0]  tbc_cnt;
    wire  logic  ext;
    wire  logic [1:0] alt_out;
    wire  logic [1:0] alt_oe;
    logic [1:0]  pin;
    logic [1:0]  pin_oe;
    logic        irq;
    int          miscompares;
    int          total_checks;

    tmcc_top #(.CNT_W(CNT_W), .HAS_CMPB(1)) u_tmcc_top
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_count_clock_pin_i(ext),
        .time_base_clock_i(tbc), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
        .timer_output_pin_o(pin), .timer_output_pin_oe_o(pin_oe),
        .irq_o(irq)
    );

    tmcc_pin_partner u_tmcc_pin_partner
    (
        .clk_i(clk_i), .ext_o(ext), .alt_out_o(alt_out), .alt_oe_o(alt_oe)
    );

    always #5 clk_i = ~clk_i;

    // One-cycle time-base tick every eight clocks
    always @(posedge clk_i)
    begin
        tbc_cnt <= tbc_cnt + 3'h1;
        tbc     <= (tbc_cnt == 3'h7);
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want)
        begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, want);
        end
    endtask

    // Classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 40);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (n >= 40)
        begin
            miscompares++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic [31:0] c0;
        logic [7:0]  ra [4] = '{`TMCC_ADR_CTRL, `TMCC_ADR_PENA,
                                `TMCC_ADR_PENB, 8'h24};
        logic [31:0] rv [4] = '{`TMCC_CTRL_RST, `TMCC_PENA_RST,
                                `TMCC_PENB_RST, 32'h0};
        for (int i = 0; i < 4; i++)
        begin
            rd(ra[i], q);
            chk(q, rv[i]);
        end
        rd(`TMCC_ADR_COUNT, c0);
        wr(`TMCC_ADR_COUNT, 32'h55);
        repeat (20) @(posedge clk_i);
        rd(`TMCC_ADR_COUNT, q);
        chk(q, c0);
    endtask

    task automatic t_ext();
        logic [31:0] c0;
        logic [31:0] c1;
        logic [9:0]  ctl [4] = '{10'h006, 10'h007, 10'h006, 10'h005};
        logic [7:0]  pb [4] = '{8'h11, 8'h11, 8'h10, 8'h11};
        bit          hi [4] = '{1, 0, 0, 0};
        logic [31:0] want [4] = '{32'h4, 32'h4, 32'h0, 32'h0};
        for (int i = 0; i < 4; i++)
        begin
            wr(`TMCC_ADR_PENB, {24'h0, pb[i]});
            wr(`TMCC_ADR_CTRL, {22'h0, ctl[i]});
            rd(`TMCC_ADR_COUNT, c0);
            u_tmcc_pin_partner.pulses(3, hi[i]);
            rd(`TMCC_ADR_COUNT, c1);
            chk((c1 - c0) & CMAX, want[i]);
        end
    endtask

    task automatic t_rate();
        logic [31:0] c0;
        logic [31:0] c1;
        logic [2:0]  cs [4] = '{3'h0, 3'h3, 3'h4, 3'h2};
        int          lo [4] = '{20, 1, 10, 5};
        for (int i = 0; i < 4; i++)
        begin
            wr(`TMCC_ADR_CTRL, {29'h0, cs[i]});
            rd(`TMCC_ADR_COUNT, c0);
            repeat (80) @(posedge clk_i);
            rd(`TMCC_ADR_COUNT, c1);
            c1 = (c1 - c0) & CMAX;
            chk({31'h0, c1 inside {[lo[i]:lo[i] + 1]}}, 32'h1);
        end
    endtask

    task automatic t_irq();
        logic [31:0] q;
        wr(`TMCC_ADR_CMPA, 32'h3);
        wr(`TMCC_ADR_CMPB, 32'h5);
        wr(`TMCC_ADR_CMPP, 32'h9);
        wr(`TMCC_ADR_MASK, 32'h0);
        wr(`TMCC_ADR_STAT, 32'h7);
        // Full clock, clear on P; wait covers one wrap
        wr(`TMCC_ADR_CTRL, 32'h009);
        repeat (1100) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        rd(`TMCC_ADR_STAT, q);
        chk(q, 32'h7);
        rd(`TMCC_ADR_COUNT, q);
        chk({31'h0, q <= 32'h9}, 32'h1);
        wr(`TMCC_ADR_MASK, 32'h4);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1);
        wr(`TMCC_ADR_CTRL, 32'h005);
        wr(`TMCC_ADR_STAT, 32'h7);
        rd(`TMCC_ADR_STAT, q);
        chk(q, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic observe(output int hi, output int ed);
        logic p;
        hi = 0;
        ed = 0;
        repeat (20) @(posedge clk_i);
        p = pin[0];
        repeat (40)
        begin
            @(posedge clk_i);
            hi += (pin[0] === 1'b1);
            ed += (pin[0] !== p);
            p = pin[0];
        end
    endtask

    task automatic t_out();
        logic [9:0] ctl [4] = '{10'h049, 10'h029, 10'h249, 10'h149};
        logic [1:0] lvl [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
        int         hi;
        int         ed;
        wr(`TMCC_ADR_PENA, 32'h93);
        for (int i = 0; i < 4; i++)
        begin
            wr(`TMCC_ADR_CTRL, {22'h0, ctl[i]});
            repeat (30) @(posedge clk_i);
            chk({28'h0, pin_oe, pin}, {28'h0, 2'b11, lvl[i]});
        end
        // Period ten with A at three (four when also clearing on A): one toggle, or three high cycles
        wr(`TMCC_ADR_CTRL, 32'h069);
        observe(hi, ed);
        chk(ed, 32'd4);
        wr(`TMCC_ADR_CTRL, 32'h079);
        observe(hi, ed);
        chk(ed, 32'd10);
        wr(`TMCC_ADR_CTRL, 32'h089);
        observe(hi, ed);
        chk(hi, 32'd12);
    endtask

    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        tbc = 1'b0;
        tbc_cnt = 3'h0;
        miscompares = 0;
        total_checks = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_ext();
        t_rate();
        t_irq();
        t_out();
        wrap_up();
    end
endmodule

bind tmcc_top tmcc_top_props #(.CNT_W(CNT_W), .HAS_CMPB(HAS_CMPB)) u_props
(
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_count_clock_pin_i(ext_count_clock_pin_i),
    .time_base_clock_i(time_base_clock_i), .alt_out_i(alt_out_i),
    .alt_oe_i(alt_oe_i), .timer_output_pin_o(timer_output_pin_o),
    .timer_output_pin_oe_o(timer_output_pin_oe_o), .irq_o(irq_o)
);

`default_nettype wire
